/* File: rtl/sbt_pkg.sv */
package sbt_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } sbt_state_e;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  typedef logic [IR_W-1:0] sbt_ir_t;

  // Instruction codes
  localparam sbt_ir_t INS_EXTEST   = 3'h0;
  localparam sbt_ir_t INS_IDCODE   = 3'h1;
  localparam sbt_ir_t INS_SAMPLE_Z = 3'h2;
  localparam sbt_ir_t INS_SAMPLE   = 3'h4;
  localparam sbt_ir_t INS_BYPASS   = 3'h7;

  // Low pair loaded in capture-instruction
  localparam logic [1:0] IR_CAPTURE = 2'h1;

  // Identification code, value arbitrary
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_5a4b;

  // Scan pins as seen at the device; an enable low means the pin floats
  typedef struct packed {
    logic tck;
    logic tms;
    logic tms_en;
    logic tdi;
    logic tdi_en;
  } sbt_pins_s;

  // Effect of the loaded instruction on the RAM's pins
  typedef struct packed {
    logic drive_bsr;
    logic outputs_hiz;
  } sbt_ctrl_s;

endpackage

/* File: rtl/sbt_tap_fsm.sv */
`timescale 1ns/10ps
module sbt_tap_fsm (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              step,
  input  wire logic              tms,
  output sbt_pkg::sbt_state_e    state
);
  import sbt_pkg::*;

  sbt_state_e state_r;
  sbt_state_e state_nxt;

  assign state = state_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TAP_RESET:    state_nxt = tms ? TAP_RESET   : TAP_IDLE;
      TAP_IDLE:     state_nxt = tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_DR:   state_nxt = tms ? TAP_SEL_IR  : TAP_CAP_DR;
      TAP_CAP_DR:   state_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_nxt = tms ? TAP_UPD_DR  : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_nxt = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_nxt = tms ? TAP_UPD_DR  : TAP_SHIFT_DR;
      TAP_UPD_DR:   state_nxt = tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_IR:   state_nxt = tms ? TAP_RESET   : TAP_CAP_IR;
      TAP_CAP_IR:   state_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_nxt = tms ? TAP_UPD_IR  : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_nxt = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_nxt = tms ? TAP_UPD_IR  : TAP_SHIFT_IR;
      TAP_UPD_IR:   state_nxt = tms ? TAP_SEL_DR  : TAP_IDLE;
      default:      state_nxt = TAP_RESET;
    endcase
  end

  // Five high samples reach reset from any state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= TAP_RESET;
    end else if (step) begin
      state_r <= state_nxt;
    end
  end

endmodule

/* File: rtl/sbt_tap.sv */
// What this block does
// - Inputs on test clock rise, outputs on fall
// - Mode-select steers controller; undriven reads one
// - Data-in feeds selected register; undriven reads one
// - Data-out active only when needed, changes on fall
// - Five high mode-select edges force reset state
// - Controller resets itself at power-up
// - Reset state held after reset, RAM unaffected until clocked
// - One register between data-in and data-out
// - Registers shift in on rise, out on fall
// - Instruction register and codes are three bits
// - Instruction loads only while it is selected
// - Reset state loads identification-read instruction
// - Instruction acts in idle and data states
// - Capture-instruction loads low bits with 01
// - New instruction waits for update-instruction state
// - Bypass path is a single flip-flop
// - 32-bit identification shifts out bit 0 first
`timescale 1ns/10ps
module sbt_tap #(
  parameter int              BSR_LEN = 8,
  parameter logic [31:0]     ID_CODE = sbt_pkg::ID_DEFAULT
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire sbt_pkg::sbt_pins_s     pins,
  input  wire logic [BSR_LEN-1:0]     bsr_capture,
  output logic                        tdo,
  output logic                        tdo_oe,
  output logic [BSR_LEN-1:0]          bsr_drive,
  output sbt_pkg::sbt_ctrl_s          ram_ctrl,
  output sbt_pkg::sbt_state_e         tap_state
);
  import sbt_pkg::*;

  logic        tck_s1_r;
  logic        tck_s2_r;
  logic        tck_s3_r;
  logic        tms_s1_r;
  logic        tms_s2_r;
  logic        tdi_s1_r;
  logic        tdi_s2_r;
  logic        tms_en_s1_r;
  logic        tms_en_s2_r;
  logic        tdi_en_s1_r;
  logic        tdi_en_s2_r;
  logic        tck_rise;
  logic        tck_fall;
  logic        tms_eff;
  logic        tdi_eff;
  sbt_state_e  state;
  sbt_ir_t     ir_shift_r;
  sbt_ir_t     ir_r;
  logic        bypass_r;
  logic [ID_W-1:0]    id_r;
  logic [BSR_LEN-1:0] bsr_r;
  logic [BSR_LEN-1:0] bsr_upd_r;
  logic        tdo_r;
  logic        tdo_oe_r;
  logic        sel_bit;

  function automatic logic is_bsr_ins(input sbt_ir_t ins);
    return (ins == INS_EXTEST) || (ins == INS_SAMPLE) || (ins == INS_SAMPLE_Z);
  endfunction

  // Unused codes behave as bypass
  function automatic logic is_bypass_ins(input sbt_ir_t ins);
    return !is_bsr_ins(ins) && (ins != INS_IDCODE);
  endfunction

  // Test pins and their drive flags cross into ref_clk with equal latency
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tck_s1_r    <= 1'b0;
      tck_s2_r    <= 1'b0;
      tck_s3_r    <= 1'b0;
      tms_s1_r    <= 1'b1;
      tms_s2_r    <= 1'b1;
      tdi_s1_r    <= 1'b1;
      tdi_s2_r    <= 1'b1;
      tms_en_s1_r <= 1'b1;
      tms_en_s2_r <= 1'b1;
      tdi_en_s1_r <= 1'b1;
      tdi_en_s2_r <= 1'b1;
    end else begin
      tck_s1_r    <= pins.tck;
      tck_s2_r    <= tck_s1_r;
      tck_s3_r    <= tck_s2_r;
      tms_s1_r    <= pins.tms;
      tms_s2_r    <= tms_s1_r;
      tdi_s1_r    <= pins.tdi;
      tdi_s2_r    <= tdi_s1_r;
      tms_en_s1_r <= pins.tms_en;
      tms_en_s2_r <= tms_en_s1_r;
      tdi_en_s1_r <= pins.tdi_en;
      tdi_en_s2_r <= tdi_en_s1_r;
    end
  end

  // Without test clock edges nothing below moves
  assign tck_rise = tck_s2_r & ~tck_s3_r;
  assign tck_fall = ~tck_s2_r & tck_s3_r;
  // A released pin reads high
  assign tms_eff  = tms_en_s2_r ? tms_s2_r : 1'b1;
  assign tdi_eff  = tdi_en_s2_r ? tdi_s2_r : 1'b1;

  sbt_tap_fsm u_fsm (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .step    (tck_rise),
    .tms     (tms_eff),
    .state   (state)
  );

  // Instruction shift stage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ir_shift_r <= INS_IDCODE;
    end else if (tck_rise) begin
      case (state)
        TAP_CAP_IR:   ir_shift_r <= {ir_r[IR_W-1:2], IR_CAPTURE};
        TAP_SHIFT_IR: ir_shift_r <= {tdi_eff, ir_shift_r[IR_W-1:1]};
        default:      ir_shift_r <= ir_shift_r;
      endcase
    end
  end

  // Active instruction
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ir_r <= INS_IDCODE;
    end else if (state == TAP_RESET) begin
      ir_r <= INS_IDCODE;
    end else if (tck_fall && state == TAP_UPD_IR) begin
      ir_r <= ir_shift_r;
    end
  end

  // Bypass stage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bypass_r <= 1'b0;
    end else if (tck_rise && is_bypass_ins(ir_r)) begin
      if (state == TAP_CAP_DR) begin
        bypass_r <= 1'b0;
      end else if (state == TAP_SHIFT_DR) begin
        bypass_r <= tdi_eff;
      end
    end
  end

  // Identification register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      id_r <= '0;
    end else if (tck_rise && ir_r == INS_IDCODE) begin
      if (state == TAP_CAP_DR) begin
        id_r <= ID_CODE;
      end else if (state == TAP_SHIFT_DR) begin
        id_r <= {tdi_eff, id_r[ID_W-1:1]};
      end
    end
  end

  // Boundary register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bsr_r <= '0;
    end else if (tck_rise && is_bsr_ins(ir_r)) begin
      if (state == TAP_CAP_DR) begin
        bsr_r <= bsr_capture;
      end else if (state == TAP_SHIFT_DR) begin
        bsr_r <= {tdi_eff, bsr_r[BSR_LEN-1:1]};
      end
    end
  end

  // Boundary update stage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bsr_upd_r <= '0;
    end else if (tck_fall && state == TAP_UPD_DR && is_bsr_ins(ir_r)) begin
      bsr_upd_r <= bsr_r;
    end
  end

  // Only one register reaches data-out
  always_comb begin
    sel_bit = bypass_r;
    if (state == TAP_SHIFT_IR) begin
      sel_bit = ir_shift_r[0];
    end else if (ir_r == INS_IDCODE) begin
      sel_bit = id_r[0];
    end else if (is_bsr_ins(ir_r)) begin
      sel_bit = bsr_r[0];
    end
  end

  // Data-out launched on the falling edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tdo_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= sel_bit;
    end
  end

  // Enable follows the shift states, also from the falling edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= (state == TAP_SHIFT_DR) || (state == TAP_SHIFT_IR);
    end
  end

  // Pin control held off after reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ram_ctrl <= '0;
    end else begin
      ram_ctrl.drive_bsr   <= (ir_r == INS_EXTEST);
      ram_ctrl.outputs_hiz <= (ir_r == INS_SAMPLE_Z);
    end
  end

  assign tdo       = tdo_r;
  assign tdo_oe    = tdo_oe_r;
  assign bsr_drive = bsr_upd_r;
  assign tap_state = state;

endmodule

/* File: verif/sbt_tap_asserts.sv */
`timescale 1ns/10ps
module sbt_tap_asserts #(
  parameter int          BSR_LEN = 8,
  parameter logic [31:0] ID_CODE = sbt_pkg::ID_DEFAULT
) (
  input wire logic                ref_clk,
  input wire logic                rstn,
  input wire sbt_pkg::sbt_pins_s  pins,
  input wire logic [BSR_LEN-1:0]  bsr_capture,
  input wire logic                tdo,
  input wire logic                tdo_oe,
  input wire logic [BSR_LEN-1:0]  bsr_drive,
  input wire sbt_pkg::sbt_ctrl_s  ram_ctrl,
  input wire sbt_pkg::sbt_state_e tap_state
);
  import sbt_pkg::*;
  logic       tck_d;
  logic [2:0] ones_r;
  wire        tms_v = pins.tms | ~pins.tms_en;
  wire        rise  = pins.tck & ~tck_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Counts consecutive high mode-select rises, saturating at four
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tck_d <= 1'b0;
      ones_r <= 3'h0;
    end else begin
      tck_d <= pins.tck;
      if (rise)
        ones_r <= tms_v ? ((ones_r == 3'h4) ? ones_r : ones_r + 3'h1) : 3'h0;
    end
  end
  a_five_ones: assert property (rise && tms_v && ones_r == 3'h4 |-> ##[2:6] tap_state == TAP_RESET)
    else $error("five high mode-select rises did not reach reset");
  a_oe_shift: assert property (tdo_oe |-> tap_state inside {TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_SHIFT_IR, TAP_EXIT1_IR}) else $error("data-out enabled outside shift");
  a_out_fall: assert property ($changed(tdo) || $changed(tdo_oe) |-> !pins.tck)
    else $error("data-out changed while test clock high");
  a_state_rise: assert property ($changed(tap_state) |-> pins.tck)
    else $error("state moved while test clock low");
  a_reset_ctrl: assert property (tap_state == TAP_RESET [*3] |-> ram_ctrl == 2'h0)
    else $error("reset state without default instruction");
  a_reset_exit: assert property ($changed(tap_state) && $past(tap_state) == TAP_RESET
      |-> tap_state == TAP_IDLE) else $error("bad exit from reset");
  a_capdr_next: assert property ($changed(tap_state) && $past(tap_state) == TAP_CAP_DR
      |-> tap_state inside {TAP_SHIFT_DR, TAP_EXIT1_DR}) else $error("bad exit from capture-DR");
  a_updir_next: assert property ($changed(tap_state) && $past(tap_state) == TAP_UPD_IR
      |-> tap_state inside {TAP_IDLE, TAP_SEL_DR}) else $error("bad exit from update-IR");
endmodule
bind sbt_tap sbt_tap_asserts #(.BSR_LEN(BSR_LEN), .ID_CODE(ID_CODE)) chk_u (.ref_clk(ref_clk), .rstn(rstn),
  .pins(pins), .bsr_capture(bsr_capture), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_drive(bsr_drive),
  .ram_ctrl(ram_ctrl), .tap_state(tap_state));

/* File: verif/sbt_tester.sv */
`timescale 1ns/10ps
module sbt_tester (
  input  wire logic          ref_clk,
  output sbt_pkg::sbt_pins_s pins,
  input  wire logic          tdo,
  input  wire logic          tdo_oe
);
  import sbt_pkg::*;
  initial pins = '{tck: 1'b0, tms: 1'b1, tms_en: 1'b1, tdi: 1'b1, tdi_en: 1'b1};
  // One test-clock period; pins change only while the clock is low
  // En holds the drive flags of mode-select and data-in, in that order
  task automatic clk_bit(input logic m, input logic d, input logic [1:0] en, output logic o);
    @(posedge ref_clk);
    #1;
    pins.tms_en = en[1];
    pins.tdi_en = en[0];
    // A released pin shows low; the device must still read it as high
    pins.tms = m & en[1];
    pins.tdi = d & en[0];
    repeat (7) @(posedge ref_clk);
    #1;
    o = tdo_oe ? tdo : 1'bz;
    pins.tck = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    pins.tck = 1'b0;
  endtask
endmodule

/* File: verif/sbt_tap_tb_top.sv */
`timescale 1ns/10ps
module sbt_tap_tb_top;
  import sbt_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  sbt_pins_s  pins;
  logic       tdo;
  logic       tdo_oe;
  logic [7:0] bsr_drive;
  sbt_ctrl_s  ram_ctrl;
  sbt_state_e tap_state;
  int         n_fail = 0;
  int         n_compared = 0;
  logic [31:0] q;
  always #5 ref_clk = ~ref_clk;
  sbt_tester tst_u (.ref_clk(ref_clk), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe));
  sbt_tap dut_u (.ref_clk(ref_clk), .rstn(rstn), .pins(pins), .bsr_capture(8'h3c), .tdo(tdo),
    .tdo_oe(tdo_oe), .bsr_drive(bsr_drive), .ram_ctrl(ram_ctrl), .tap_state(tap_state));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic walk(input logic [7:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++)
      tst_u.clk_bit(m[i], 1'b0, 2'h3, o);
  endtask
  // Shifts n bits LSB first, mode-select high on the last
  task automatic shift(input int n, input logic [31:0] d, output logic [31:0] r);
    r = '0;
    for (int i = 0; i < n; i++)
      tst_u.clk_bit(i == n - 1, d[i], 2'h3, r[i]);
  endtask
  task automatic load_ir(input logic [2:0] code, output logic [31:0] r);
    walk(8'h03, 4);
    shift(3, {29'h0, code}, r);
    walk(8'h01, 2);
  endtask
  task automatic t_power();
    repeat (20) @(posedge ref_clk);
    #1;
    chk(tap_state, TAP_RESET);
    chk({tdo_oe, ram_ctrl}, 3'h0);
  endtask
  task automatic t_idcode();
    walk(8'h02, 4);
    shift(32, 32'h0, q);
    chk(q, ID_DEFAULT);
    walk(8'h01, 2);
    repeat (8) @(posedge ref_clk);
    chk(tdo_oe, 1'b0);
  endtask
  task automatic t_bypass();
    logic o;
    load_ir(INS_BYPASS, q);
    chk(q[2:0], {1'b0, IR_CAPTURE});
    walk(8'h01, 3);
    shift(4, 32'hb, q);
    chk(q[3:0], 4'h6);
    walk(8'h01, 2);
    // Data-in released: the bypass stage must pick up a one
    walk(8'h01, 3);
    tst_u.clk_bit(1'b0, 1'b0, 2'h2, o);
    chk(o, 1'b0);
    tst_u.clk_bit(1'b1, 1'b0, 2'h2, o);
    chk(o, 1'b1);
    walk(8'h01, 2);
  endtask
  task automatic t_extest_reset();
    logic o;
    load_ir(INS_EXTEST, q);
    chk(ram_ctrl, 2'h2);
    walk(8'h01, 3);
    shift(8, 32'ha5, q);
    chk(q[7:0], 8'h3c);
    walk(8'h01, 2);
    chk(bsr_drive, 8'ha5);
    load_ir(INS_SAMPLE_Z, q);
    chk(q[2:0], {1'b0, IR_CAPTURE});
    chk(ram_ctrl, 2'h1);
    // Five released mode-select rises from deep inside the data column
    walk(8'h01, 3);
    for (int i = 0; i < 5; i++)
      tst_u.clk_bit(1'b0, 1'b0, 2'h0, o);
    repeat (8) @(posedge ref_clk);
    chk(tap_state, TAP_RESET);
    chk(ram_ctrl, 2'h0);
  endtask
  task automatic summarize();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    t_power();
    t_idcode();
    t_bypass();
    t_extest_reset();
    summarize();
  end
endmodule
